// >>> hw/interval_timer_pkg.sv
// Constants, register map and carrier types of the three-channel interval timer.
// Assumes a single system clock; register indices are scaled by four into byte addresses.
package interval_timer_pkg;
    localparam int NUM_CH = 3;
    localparam int CNT_W = 8;
    localparam int CODE_W = 3;
    localparam int PRE_W = 13;
    localparam int IDX_W = 16;

    // Register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_COUNT_VALUE_0 = 16'hFF16;
    localparam logic [IDX_W-1:0] IDX_COUNT_VALUE_1 = 16'hFF6F;
    localparam logic [IDX_W-1:0] IDX_COUNT_VALUE_2 = 16'hFF51;
    localparam logic [IDX_W-1:0] IDX_CLOCK_SELECT_0 = 16'hFF6A;
    localparam logic [IDX_W-1:0] IDX_CLOCK_SELECT_1 = 16'hFF8C;
    localparam logic [IDX_W-1:0] IDX_CLOCK_SELECT_2 = 16'hFF5B;
    localparam logic [IDX_W-1:0] IDX_MODE_CONTROL_0 = 16'hFF6B;
    localparam logic [IDX_W-1:0] IDX_MODE_CONTROL_1 = 16'hFF43;
    localparam logic [IDX_W-1:0] IDX_MODE_CONTROL_2 = 16'hFF5C;
    localparam logic [IDX_W-1:0] IDX_EVENT_GATE = 16'hFF4F;
    localparam logic [IDX_W-1:0] IDX_MATCH_VALUE_0 = 16'hFF18;
    localparam logic [IDX_W-1:0] IDX_MATCH_VALUE_1 = 16'hFF19;
    localparam logic [IDX_W-1:0] IDX_MATCH_VALUE_2 = 16'hFF1A;
    localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 16'hFF20;
    localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 16'hFF21;

    localparam logic [IDX_W-1:0] IDX_COUNT_VALUE [NUM_CH] = '{16'hFF16, 16'hFF6F, 16'hFF51};
    localparam logic [IDX_W-1:0] IDX_CLOCK_SELECT [NUM_CH] = '{16'hFF6A, 16'hFF8C, 16'hFF5B};
    localparam logic [IDX_W-1:0] IDX_MODE_CONTROL [NUM_CH] = '{16'hFF6B, 16'hFF43, 16'hFF5C};
    localparam logic [IDX_W-1:0] IDX_MATCH_VALUE [NUM_CH] = '{16'hFF18, 16'hFF19, 16'hFF1A};

    localparam int BIT_COUNT_ENABLE = 7;
    localparam int BIT_EVENT_GATE = 2;
    localparam logic [CNT_W-1:0] CNT_RESET = 8'h00;
    localparam logic [CNT_W-1:0] MATCH_RESET = 8'h00;
    localparam logic [CODE_W-1:0] CODE_RESET = 3'h0;

    // Clock select codes
    localparam logic [CODE_W-1:0] CODE_EDGE_FALL = 3'h0;
    localparam logic [CODE_W-1:0] CODE_EDGE_RISE = 3'h1;
    localparam logic [CODE_W-1:0] CODE_DIV_A = 3'h2;
    localparam logic [CODE_W-1:0] CODE_DIV_B = 3'h3;
    localparam logic [CODE_W-1:0] CODE_DIV_C = 3'h4;
    localparam logic [CODE_W-1:0] CODE_DIV_D = 3'h5;
    localparam logic [CODE_W-1:0] CODE_DIV_E = 3'h6;
    localparam logic [CODE_W-1:0] CODE_DIV_F = 3'h7;

    // Divider exponents per channel for codes 010..111 (power of two)
    localparam logic [3:0] DIV_EXP [NUM_CH][6] = '{
        '{4'h0, 4'h1, 4'h2, 4'h6, 4'h8, 4'hD},
        '{4'h0, 4'h1, 4'h4, 4'h6, 4'h8, 4'h0},
        '{4'h0, 4'h1, 4'h4, 4'h6, 4'h8, 4'hC}
    };

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'b0;

    typedef struct packed {
        logic enable;
        logic [CODE_W-1:0] code;
        logic [CNT_W-1:0] match;
    } chan_cfg_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [31:0] addr;
    } bus_phase_t;

    function automatic logic [31:0] byte_addr(input logic [IDX_W-1:0] idx);
        byte_addr = {14'h0000, idx, 2'h0};
    endfunction : byte_addr
endpackage : interval_timer_pkg

// >>> hw/interval_timer.sv
// Three 8-bit interval/event counters with match interrupts behind an AHB-Lite slave.
// Assumes a zero-wait-state AHB-Lite master; event, gate and companion inputs are asynchronous.
// What this block does
// (RL1) Each channel holds an 8-bit up-counter that adds one on every selected count clock tick.
// (RL2) The counter is read-only and bus writes never alter the count.
// (RL3) The counter returns to 00H on reset, when counting is disabled, and on a match.
// (RL4) The counter is compared with the match value on each count tick while enabled, and equality on that tick raises the request.
// (RL5) The match value takes any 8-bit value from 00H to FFH and each value is used as it is.
// (RL6) The match value is read and written by the bus and resets to 00H.
// (RL7) The match value is only handled as a whole 8-bit quantity.
// (RL8) Software changes the match value only while the counter is stopped.
// (RL9) The clock select register picks count clock and event edge, takes writes, resets to 00H.
// (RL10) Channel 0 codes 010 to 111 give the clock divided by 1, 2, 4, 64, 256 and 8192.
// (RL11) Channel 1 codes 010 to 110 give divide by 1, 2, 16, 64, 256 and 111 the companion output.
// (RL12) Software stops the counter before writing a new clock select value.
// (RL13) Software writes zeros into bits 3 to 7 of the clock select register.
// (RL14) Bit 7 of the mode control register enables counting, and clearing it stops and clears.
// (RL15) Channel 2 codes 000 and 001 count falling or rising edges of the gated event input.
// (RL16) On a match the request pulses for one system clock cycle and the clear happens on the match tick.
`timescale 1ns/1ps
module interval_timer (
    input wire logic CLK_SYS,
    input wire logic ARST_N,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic EVENT_IN_PIN,
    input wire logic EVENT_GATE_IN,
    input wire logic COMPANION_TIMER_OUTPUT,
    output logic [interval_timer_pkg::NUM_CH-1:0] MATCH_INTERRUPT_REQUEST,
    output logic IRQ
);
    import interval_timer_pkg::*;

    typedef enum logic [1:0] {
        SYNC_A = 2'b00,
        SYNC_B = 2'b01,
        SYNC_C = 2'b10
    } sync_slot_t;

    function automatic logic div_tick(input logic [PRE_W-1:0] pre, input logic [3:0] expo);
        logic [PRE_W-1:0] mask;
        mask = PRE_W'((14'h0001 << expo) - 14'h0001);
        div_tick = ((pre & mask) == mask);
    endfunction : div_tick

    logic [PRE_W-1:0] pre_q, pre_d;
    logic [2:0] sync1_q, sync2_q, sync3_q;
    logic [2:0] sync1_d, sync2_d, sync3_d;
    chan_cfg_t cfg_q [NUM_CH];
    chan_cfg_t cfg_d [NUM_CH];
    logic [CNT_W-1:0] cnt_q [NUM_CH];
    logic [CNT_W-1:0] cnt_d [NUM_CH];
    logic [NUM_CH-1:0] match_irq_q, match_irq_d;
    logic [NUM_CH-1:0] status_q, status_d;
    logic [NUM_CH-1:0] mask_q, mask_d;
    logic gate_en_q, gate_en_d;
    bus_phase_t phase_q, phase_d;
    logic [31:0] rdata_q, rdata_d;
    logic [NUM_CH-1:0] tick;
    logic ev_rise, ev_fall, comp_rise, ev_pass_now, ev_pass_old;
    logic addr_take, status_read;

    // Prescaler and input synchronisers
    always_comb begin
        pre_d = pre_q + PRE_W'(1);
        sync1_d = {COMPANION_TIMER_OUTPUT, EVENT_GATE_IN, EVENT_IN_PIN};
        sync2_d = sync1_q;
        sync3_d = sync2_q;
    end

    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            pre_q <= '0;
            sync1_q <= '0;
            sync2_q <= '0;
            sync3_q <= '0;
        end else begin
            pre_q <= pre_d;
            sync1_q <= sync1_d;
            sync2_q <= sync2_d;
            sync3_q <= sync3_d;
        end
    end

    // Gate forced open when gating is off, so the event edge passes straight through
    // (RL15) Gated event edges
    always_comb begin
        ev_pass_now = sync2_q[SYNC_A] & (~gate_en_q | sync2_q[SYNC_B]);
        ev_pass_old = sync3_q[SYNC_A] & (~gate_en_q | sync3_q[SYNC_B]);
        ev_rise = ev_pass_now & ~ev_pass_old;
        ev_fall = ~ev_pass_now & ev_pass_old;
        comp_rise = sync2_q[SYNC_C] & ~sync3_q[SYNC_C];
    end

    // (RL10) (RL11) Count clock selection
    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            case (cfg_q[i].code)
                CODE_EDGE_FALL: tick[i] = (i == 2) ? ev_fall : 1'b0;
                CODE_EDGE_RISE: tick[i] = (i == 2) ? ev_rise : 1'b0;
                CODE_DIV_A: tick[i] = div_tick(pre_q, DIV_EXP[i][0]);
                CODE_DIV_B: tick[i] = div_tick(pre_q, DIV_EXP[i][1]);
                CODE_DIV_C: tick[i] = div_tick(pre_q, DIV_EXP[i][2]);
                CODE_DIV_D: tick[i] = div_tick(pre_q, DIV_EXP[i][3]);
                CODE_DIV_E: tick[i] = div_tick(pre_q, DIV_EXP[i][4]);
                CODE_DIV_F: tick[i] = (i == 1) ? comp_rise : div_tick(pre_q, DIV_EXP[i][5]);
                default: tick[i] = 1'b0;
            endcase
        end
    end

    // Counters, match detection and sticky status
    always_comb begin
        status_d = status_q;
        if (status_read) begin
            status_d = '0;
        end
        for (int i = 0; i < NUM_CH; i++) begin
            cnt_d[i] = cnt_q[i];
            match_irq_d[i] = 1'b0;
            if (!cfg_q[i].enable) begin
                // (RL3) (RL14) Disabled clears count
                cnt_d[i] = CNT_RESET;
            end else if (tick[i]) begin
                if (cnt_q[i] == cfg_q[i].match) begin
                    // (RL4) (RL16) Match clears and pulses
                    cnt_d[i] = CNT_RESET;
                    match_irq_d[i] = 1'b1;
                end else begin
                    // (RL1) Increment on tick
                    cnt_d[i] = cnt_q[i] + CNT_W'(1);
                end
            end
        end
        // New events win over a read-clear in the same cycle
        status_d = status_d | match_irq_d;
    end

    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            for (int i = 0; i < NUM_CH; i++) begin
                cnt_q[i] <= CNT_RESET;
            end
            match_irq_q <= '0;
            status_q <= '0;
        end else begin
            cnt_q <= cnt_d;
            match_irq_q <= match_irq_d;
            status_q <= status_d;
        end
    end

    // Bus address phase and read data
    always_comb begin
        addr_take = HSEL & HREADY & (HTRANS == HTRANS_NONSEQ);
        phase_d.valid = addr_take;
        phase_d.write = HWRITE;
        phase_d.addr = HADDR;
        status_read = addr_take & ~HWRITE & (HADDR == byte_addr(IDX_IRQ_STATUS));
        rdata_d = rdata_q;
        if (addr_take && !HWRITE) begin
            rdata_d = '0;
            for (int i = 0; i < NUM_CH; i++) begin
                if (HADDR == byte_addr(IDX_COUNT_VALUE[i])) begin
                    rdata_d[CNT_W-1:0] = cnt_q[i];
                end
                if (HADDR == byte_addr(IDX_CLOCK_SELECT[i])) begin
                    rdata_d[CODE_W-1:0] = cfg_q[i].code;
                end
                if (HADDR == byte_addr(IDX_MODE_CONTROL[i])) begin
                    rdata_d[BIT_COUNT_ENABLE] = cfg_q[i].enable;
                end
                if (HADDR == byte_addr(IDX_MATCH_VALUE[i])) begin
                    rdata_d[CNT_W-1:0] = cfg_q[i].match;
                end
            end
            if (HADDR == byte_addr(IDX_EVENT_GATE)) begin
                rdata_d[BIT_EVENT_GATE] = gate_en_q;
            end
            if (HADDR == byte_addr(IDX_IRQ_STATUS)) begin
                rdata_d[NUM_CH-1:0] = status_q;
            end
            if (HADDR == byte_addr(IDX_IRQ_MASK)) begin
                rdata_d[NUM_CH-1:0] = mask_q;
            end
        end
    end

    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            phase_q <= '0;
            rdata_q <= '0;
        end else begin
            phase_q <= phase_d;
            rdata_q <= rdata_d;
        end
    end

    // Register writes in the data phase
    always_comb begin
        cfg_d = cfg_q;
        mask_d = mask_q;
        gate_en_d = gate_en_q;
        if (phase_q.valid && phase_q.write) begin
            for (int i = 0; i < NUM_CH; i++) begin
                // (RL9) Clock select write; upper bits not stored
                if (phase_q.addr == byte_addr(IDX_CLOCK_SELECT[i])) begin
                    cfg_d[i].code = HWDATA[CODE_W-1:0];
                end
                // (RL14) Count enable bit
                if (phase_q.addr == byte_addr(IDX_MODE_CONTROL[i])) begin
                    cfg_d[i].enable = HWDATA[BIT_COUNT_ENABLE];
                end
                // (RL5) (RL6) (RL7) Whole-byte match value
                if (phase_q.addr == byte_addr(IDX_MATCH_VALUE[i])) begin
                    cfg_d[i].match = HWDATA[CNT_W-1:0];
                end
            end
            if (phase_q.addr == byte_addr(IDX_EVENT_GATE)) begin
                gate_en_d = HWDATA[BIT_EVENT_GATE];
            end
            if (phase_q.addr == byte_addr(IDX_IRQ_MASK)) begin
                mask_d = HWDATA[NUM_CH-1:0];
            end
        end
    end

    // (RL2) Count registers have no write path
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            for (int i = 0; i < NUM_CH; i++) begin
                cfg_q[i] <= '{enable: 1'b0, code: CODE_RESET, match: MATCH_RESET};
            end
            mask_q <= '0;
            gate_en_q <= 1'b0;
        end else begin
            cfg_q <= cfg_d;
            mask_q <= mask_d;
            gate_en_q <= gate_en_d;
        end
    end

    // Zero wait states keep the slave simple; every access completes in one data phase
    assign HREADYOUT = 1'b1;
    assign HRESP = HRESP_OKAY;
    assign HRDATA = rdata_q;
    assign MATCH_INTERRUPT_REQUEST = match_irq_q;
    assign IRQ = |(status_q & mask_q);
endmodule : interval_timer

// >>> testbench/event_source.sv
// Far-side model: external event pin, its gate level and the companion timer output.
// Assumes the bench calls its tasks right after a rising edge of the system clock.
`timescale 1ns/1ps
module event_source (
    input wire logic clk,
    output logic ev_pin,
    output logic gate,
    output logic comp
);
    initial begin
        ev_pin = 1'b0;
        gate = 1'b0;
        comp = 1'b0;
    end

    task automatic burst(input int n, input logic on_comp);
        int hold;
        repeat (n) begin
            // Random hold keeps the source both prompt and slow
            hold = $urandom_range(1, 4);
            if (on_comp) comp <= 1'b1;
            else ev_pin <= 1'b1;
            repeat (hold) @(posedge clk);
            if (on_comp) comp <= 1'b0;
            else ev_pin <= 1'b0;
            repeat (hold) @(posedge clk);
        end
    endtask : burst

    task automatic set_gate(input logic v);
        gate <= v;
    endtask : set_gate
endmodule : event_source

// >>> testbench/interval_timer_props.sv
// Port-level timing checks of the interval timer.
// Bound to the top module; sees only its ports.
`timescale 1ns/1ps
module interval_timer_props (
    input wire logic CLK_SYS,
    input wire logic ARST_N,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    input wire logic [31:0] HRDATA,
    input wire logic HREADYOUT,
    input wire logic HRESP,
    input wire logic EVENT_IN_PIN,
    input wire logic EVENT_GATE_IN,
    input wire logic COMPANION_TIMER_OUTPUT,
    input wire logic [interval_timer_pkg::NUM_CH-1:0] MATCH_INTERRUPT_REQUEST,
    input wire logic IRQ
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!ARST_N);

    a_resp_okay: assert property (!HRESP)
        else $error("bus response not okay");
    a_zero_wait: assert property (HREADYOUT)
        else $error("wait state inserted");
    a_upper_zero: assert property (HRDATA[31:8] == 24'h000000)
        else $error("read data upper bits set");
    a_rdata_hold: assert property (!(HSEL && HREADY && HTRANS == 2'h2 && !HWRITE)
        |=> $stable(HRDATA)) else $error("read data changed without read");
    // Match value 00 at an undivided clock would pulse every cycle; bench avoids it
    a_pulse_ch0: assert property (MATCH_INTERRUPT_REQUEST[0] |=> !MATCH_INTERRUPT_REQUEST[0])
        else $error("channel 0 request too long");
    a_pulse_ch1: assert property (MATCH_INTERRUPT_REQUEST[1] |=> !MATCH_INTERRUPT_REQUEST[1])
        else $error("channel 1 request too long");
    a_pulse_ch2: assert property (MATCH_INTERRUPT_REQUEST[2] |=> !MATCH_INTERRUPT_REQUEST[2])
        else $error("channel 2 request too long");
    a_reset_quiet: assert property ($rose(ARST_N) |-> MATCH_INTERRUPT_REQUEST == 3'h0 && !IRQ)
        else $error("request after reset");
endmodule : interval_timer_props

bind interval_timer interval_timer_props i_props (
    .CLK_SYS(CLK_SYS),
    .ARST_N(ARST_N),
    .HSEL(HSEL),
    .HADDR(HADDR),
    .HTRANS(HTRANS),
    .HWRITE(HWRITE),
    .HSIZE(HSIZE),
    .HWDATA(HWDATA),
    .HREADY(HREADY),
    .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT),
    .HRESP(HRESP),
    .EVENT_IN_PIN(EVENT_IN_PIN),
    .EVENT_GATE_IN(EVENT_GATE_IN),
    .COMPANION_TIMER_OUTPUT(COMPANION_TIMER_OUTPUT),
    .MATCH_INTERRUPT_REQUEST(MATCH_INTERRUPT_REQUEST),
    .IRQ(IRQ)
);

// >>> testbench/tb.sv
// Self-checking bench of the interval timer: registers, divided periods, events, interrupt.
// Assumes one AHB-Lite slave whose ready output is fed back as the bus ready.
`timescale 1ns/1ps
module tb;
    import interval_timer_pkg::*;
    logic CLK_SYS, ARST_N, HSEL, HWRITE, HREADY, HREADYOUT, HRESP, IRQ;
    logic [31:0] HADDR, HWDATA, HRDATA, rd;
    logic [1:0] HTRANS;
    logic [2:0] HSIZE;
    logic [NUM_CH-1:0] MATCH_INTERRUPT_REQUEST;
    logic EVENT_IN_PIN, EVENT_GATE_IN, COMPANION_TIMER_OUTPUT;
    int bad_count, checked, n, m, p, k;
    int exps [3][6] = '{'{0, 1, 2, 6, 8, 13}, '{0, 1, 4, 6, 8, 0}, '{0, 1, 4, 6, 8, 12}};
    int ev_tab [4][3] = '{'{1, 0, 0}, '{0, 0, 0}, '{1, 1, 0}, '{0, 1, 1}};

    assign HREADY = HREADYOUT;
    interval_timer i_dut (
        .CLK_SYS(CLK_SYS),
        .ARST_N(ARST_N),
        .HSEL(HSEL),
        .HADDR(HADDR),
        .HTRANS(HTRANS),
        .HWRITE(HWRITE),
        .HSIZE(HSIZE),
        .HWDATA(HWDATA),
        .HREADY(HREADY),
        .HRDATA(HRDATA),
        .HREADYOUT(HREADYOUT),
        .HRESP(HRESP),
        .EVENT_IN_PIN(EVENT_IN_PIN),
        .EVENT_GATE_IN(EVENT_GATE_IN),
        .COMPANION_TIMER_OUTPUT(COMPANION_TIMER_OUTPUT),
        .MATCH_INTERRUPT_REQUEST(MATCH_INTERRUPT_REQUEST),
        .IRQ(IRQ)
    );
    event_source i_src (.clk(CLK_SYS), .ev_pin(EVENT_IN_PIN), .gate(EVENT_GATE_IN),
        .comp(COMPANION_TIMER_OUTPUT));

    initial begin
        CLK_SYS = 1'b0;
        forever #10 CLK_SYS = ~CLK_SYS;
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic bus(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
        HSEL <= 1'b1;
        HTRANS <= 2'h2;
        HWRITE <= wr;
        HADDR <= {14'h0, idx, 2'h0};
        do @(posedge CLK_SYS); while (HREADY !== 1'b1);
        HTRANS <= 2'h0;
        HWDATA <= wd;
        do @(posedge CLK_SYS); while (HREADY !== 1'b1);
        rd = HRDATA;
        // Idle after a write so a following read sees the new value
        if (wr) @(posedge CLK_SYS);
    endtask : bus

    task automatic setup(input int ch, input int code, input int mv);
        bus(1'b1, IDX_MODE_CONTROL[ch], 32'h0);
        bus(1'b1, IDX_MATCH_VALUE[ch], mv);
        bus(1'b1, IDX_CLOCK_SELECT[ch], code);
        bus(1'b1, IDX_MODE_CONTROL[ch], 32'h80);
    endtask : setup

    task automatic wait_pulse(input int ch, input int lim);
        n = 0;
        do begin
            @(posedge CLK_SYS);
            n++;
        end while (MATCH_INTERRUPT_REQUEST[ch] !== 1'b1 && n < lim);
    endtask : wait_pulse

    function automatic int period(input int ch, input int code, input int mv);
        return (mv + 1) << exps[ch][code-2];
    endfunction : period

    task automatic test_done();
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : test_done

    initial begin
        repeat (90000) @(posedge CLK_SYS);
        bad_count++;
        test_done();
    end

    initial begin
        {HSEL, HWRITE, HTRANS, HADDR, HWDATA} = '0;
        HSIZE = 3'h2;
        ARST_N = 1'b0;
        bad_count = 0;
        checked = 0;
        n = $urandom(48722);
        repeat (10) @(posedge CLK_SYS);
        ARST_N <= 1'b1;
        @(posedge CLK_SYS);
        for (int ch = 0; ch < NUM_CH; ch++) begin
            bus(1'b0, IDX_MATCH_VALUE[ch], 32'h0);
            chk("match reset", 32'h0, rd);
            bus(1'b0, IDX_CLOCK_SELECT[ch], 32'h0);
            chk("select reset", 32'h0, rd);
            // Enabled but never ticking, so a leaking count write would stay visible
            setup(ch, CODE_EDGE_RISE, 8'hFF);
            bus(1'b1, IDX_COUNT_VALUE[ch], 32'hA5);
            bus(1'b0, IDX_COUNT_VALUE[ch], 32'h0);
            chk("count after write", 32'h0, rd);
            bus(1'b1, IDX_MODE_CONTROL[ch], 32'h0);
            m = (ch == 0) ? 8'hFF : (ch == 1) ? 0 : $urandom_range(255);
            bus(1'b1, IDX_MATCH_VALUE[ch], m);
            bus(1'b0, IDX_MATCH_VALUE[ch], 32'h0);
            chk("match value", m, rd);
        end
        bus(1'b0, 16'hFF30, 32'h0);
        chk("unmapped", 32'h0, rd);
        for (int ch = 0; ch < NUM_CH; ch++) begin
            for (int c = 2; c <= (ch == 1 ? 6 : 7); c++) begin
                m = (c == 3) ? 0 : (c < 5) ? $urandom_range(1, 40) : 1;
                p = period(ch, c, m);
                setup(ch, c, m);
                wait_pulse(ch, 2 * p + 40);
                wait_pulse(ch, 2 * p + 40);
                chk("match period", p, n);
                bus(1'b1, IDX_MODE_CONTROL[ch], 32'h0);
                bus(1'b0, IDX_COUNT_VALUE[ch], 32'h0);
                chk("count stopped", 32'h0, rd);
            end
        end
        chk("irq masked", 32'h0, {31'h0, IRQ});
        bus(1'b1, IDX_IRQ_MASK, 32'h2);
        chk("irq unmasked", 32'h1, {31'h0, IRQ});
        bus(1'b0, IDX_IRQ_STATUS, 32'h0);
        chk("status", 32'h7, rd);
        chk("irq cleared", 32'h0, {31'h0, IRQ});
        for (int t = 0; t < 4; t++) begin
            bus(1'b1, IDX_EVENT_GATE, ev_tab[t][1] << BIT_EVENT_GATE);
            i_src.set_gate(1'(ev_tab[t][2]));
            setup(2, ev_tab[t][0], 8'hFF);
            k = $urandom_range(3, 10);
            i_src.burst(k, 1'b0);
            repeat (6) @(posedge CLK_SYS);
            bus(1'b0, IDX_COUNT_VALUE[2], 32'h0);
            chk("event count", (!ev_tab[t][1] || ev_tab[t][2]) ? k : 0, rd);
        end
        setup(1, 7, 8'hFF);
        k = $urandom_range(3, 10);
        i_src.burst(k, 1'b1);
        repeat (6) @(posedge CLK_SYS);
        bus(1'b0, IDX_COUNT_VALUE[1], 32'h0);
        chk("companion count", k, rd);
        test_done();
    end
endmodule : tb
